// >>> hdl/cmd_decoder_defines.svh
// opcode, framing and bit-count constants for the serial register command decoder
`ifndef CMD_DECODER_DEFINES_SVH
`define CMD_DECODER_DEFINES_SVH
`define OP_RESET_ENABLE 8'h66
`define OP_MEMORY_RESET 8'h99
`define OP_GANG_LOCK 8'h7E
`define OP_GANG_UNLOCK 8'h98
`define OP_READ_IDENTITY 8'h9F
`define OP_READ_PARAM_TABLE 8'h5A
`define OP_READ_STATUS 8'h05
`define OP_READ_CONFIG 8'h15
`define OP_WRITE_STATUS_CONFIG 8'h01
`define OP_READ_CONFIG_TWO 8'h71
`define OP_WRITE_CONFIG_TWO 8'h72
`define OP_READ_SECURITY 8'h2B
`define OP_WRITE_SECURITY 8'h2F
`define OP_READ_BOOT 8'h16
`define OP_WRITE_BOOT 8'h17
`define OP_ERASE_BOOT 8'h18
`define OP_SET_BURST_LEN 8'hC0
`define OP_ENTER_OTP 8'hB1
`define OP_EXIT_OTP 8'hC1
`define OP_WRITE_LOCKREG 8'h2C
`define OP_READ_LOCKREG 8'h2D
`define OP_PROGRAM_PERSIST_PROT 8'hE3
`define OP_ERASE_PERSIST_PROT 8'hE4
`define OP_READ_PERSIST_PROT 8'hE2
`define OP_WRITE_DYN_PROT 8'hE1
`define OP_READ_DYN_PROT 8'hE0
`define OP_READ_PASSCODE 8'h27
`define OP_WRITE_PASSCODE 8'h28
`define OP_PASSCODE_UNLOCK 8'h29
`define ADDR_BYTES_THREE 3'h3
`define ADDR_BYTES_FOUR 3'h4
`define ADDR_BYTES_NONE 3'h0
`define DUMMY_CYCLES_EIGHT 4'h8
`define DUMMY_CYCLES_NONE 4'h0
`define DATA_ONE 4'h1
`define DATA_TWO 4'h2
`define DATA_THREE 4'h3
`define DATA_FOUR 4'h4
`define DATA_EIGHT 4'h8
`define DATA_NONE 4'h0
`define DATA_UNBOUNDED 4'hF
`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0
`define BYTE_ZERO 8'h00
`endif

// >>> hdl/cmd_decoder_pkg.sv
// types shared by the serial register command decoder
package cmd_decoder_pkg;
	typedef enum logic [2:0] {
		PH_OPCODE = 3'b000,
		PH_ADDR = 3'b001,
		PH_DUMMY = 3'b010,
		PH_DATA = 3'b011,
		PH_STANDBY = 3'b100,
		PH_DONE = 3'b101
	} phase_t;
	typedef enum logic [4:0] {
		CMD_NONE = 5'h00,
		CMD_RESET_ENABLE = 5'h01,
		CMD_MEMORY_RESET = 5'h02,
		CMD_GANG_LOCK = 5'h03,
		CMD_GANG_UNLOCK = 5'h04,
		CMD_READ_IDENTITY = 5'h05,
		CMD_READ_PARAM_TABLE = 5'h06,
		CMD_READ_STATUS = 5'h07,
		CMD_READ_CONFIG = 5'h08,
		CMD_WRITE_STATUS_CONFIG = 5'h09,
		CMD_READ_CONFIG_TWO = 5'h0A,
		CMD_WRITE_CONFIG_TWO = 5'h0B,
		CMD_READ_SECURITY = 5'h0C,
		CMD_WRITE_SECURITY = 5'h0D,
		CMD_READ_BOOT = 5'h0E,
		CMD_WRITE_BOOT = 5'h0F,
		CMD_ERASE_BOOT = 5'h10,
		CMD_SET_BURST_LEN = 5'h11,
		CMD_ENTER_OTP = 5'h12,
		CMD_EXIT_OTP = 5'h13,
		CMD_WRITE_LOCKREG = 5'h14,
		CMD_READ_LOCKREG = 5'h15,
		CMD_PROGRAM_PERSIST_PROT = 5'h16,
		CMD_ERASE_PERSIST_PROT = 5'h17,
		CMD_READ_PERSIST_PROT = 5'h18,
		CMD_WRITE_DYN_PROT = 5'h19,
		CMD_READ_DYN_PROT = 5'h1A,
		CMD_READ_PASSCODE = 5'h1B,
		CMD_WRITE_PASSCODE = 5'h1C,
		CMD_PASSCODE_UNLOCK = 5'h1D
	} command_t;
	typedef struct packed {
		command_t cmd;
		logic [2:0] addrBytes;
		logic [3:0] dummyCycles;
		logic [3:0] dataMin;
		logic [3:0] dataMax;
		logic isRead;
		logic zeroAddr;
	} cmd_info_t;
endpackage : cmd_decoder_pkg

// >>> hdl/pin_sync.sv
// three-stage synchroniser with agreement filter for one pin input
`include "cmd_decoder_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic pinIn,
	input wire logic resetLevel,
	output logic level,
	output logic rose,
	output logic fell
);
	logic stageOne_reg;
	logic stageTwo_reg;
	logic stageThree_reg;
	logic level_next;
	// stage one feeds stage two only, to keep metastability contained
	assign level_next = (stageTwo_reg == stageThree_reg) ? stageTwo_reg : level;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stageOne_reg <= resetLevel;
			stageTwo_reg <= resetLevel;
			stageThree_reg <= resetLevel;
			level <= resetLevel;
			rose <= 1'b0;
			fell <= 1'b0;
		end else begin
			stageOne_reg <= pinIn;
			stageTwo_reg <= stageOne_reg;
			stageThree_reg <= stageTwo_reg;
			level <= level_next;
			rose <= level_next & ~level;
			fell <= ~level_next & level;
		end
	end
endmodule : pin_sync
`default_nettype wire

// >>> hdl/shift_out_byte.sv
// output shift register that moves on falling serial clock edges
`include "cmd_decoder_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module shift_out_byte (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [7:0] loadByte,
	input wire logic shift,
	output logic serialOut,
	output logic byteDone
);
	logic [7:0] shift_reg;
	logic [2:0] count_reg;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			shift_reg <= `BYTE_ZERO;
			count_reg <= `BIT_FIRST;
			serialOut <= 1'b0;
			byteDone <= 1'b0;
		end else if (load) begin
			shift_reg <= {loadByte[6:0], 1'b0};
			count_reg <= `BIT_FIRST;
			serialOut <= loadByte[7];
			byteDone <= 1'b0;
		end else if (shift) begin
			shift_reg <= {shift_reg[6:0], 1'b0};
			serialOut <= shift_reg[7];
			count_reg <= count_reg + 3'h1;
			byteDone <= (count_reg == `BIT_LAST);
		end else begin
			byteDone <= 1'b0;
		end
	end
endmodule : shift_out_byte
`default_nettype wire

// >>> hdl/spi_register_command_decoder.sv
// serial command decoder for the register-access half of the command set
// ************************************************************
// Summary of operation
// ************************************************************
// Summary of operation
// - reset-enable is lone opcode 66h, no address, dummy or data
// - memory-reset is lone opcode 99h, no address, dummy or data
// - memory-reset ignored if any other command came after reset-enable
// - gang lock 7Eh and gang unlock 98h, opcode only
// - identity read 9Fh returns three bytes
// - parameter table read 5Ah, three address bytes, eight dummy cycles
// - status read 05h returns one byte
// - configuration read 15h returns one byte
// - status/config write 01h takes one or two host bytes
// - config-two read 71h, write 72h, four address bytes, one byte
// - security read 2Bh one byte; write 2Fh no data
// - boot read 16h one to four; write 17h four; erase 18h none
// - burst length set C0h takes one host byte
// - OTP enter B1h and exit C1h, opcode only
// - lock register write 2Ch, read 2Dh, one byte each
// - persistent bit program E3h, read E2h, four address bytes
// - persistent bits erase E4h, opcode only
// - dynamic bit write E1h, read E0h, four address bytes, one byte
// - passcode read 27h, four zero address bytes, eight dummy, eight bytes
// - passcode write 28h, unlock 29h, four zero address bytes, eight bytes
// - sample on rising serial clock, shift out on falling edge
// - bad sequence: standby, output released until next select fall
`include "cmd_decoder_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module spi_register_command_decoder (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic chipSelect_n,
	input wire logic serialClock,
	input wire logic serialIn,
	output logic serialOut,
	output logic serialOutEn,
	output logic cmdValid,
	output cmd_decoder_pkg::command_t cmdCode,
	output logic [31:0] cmdAddr,
	output logic [3:0] cmdDataCount,
	output logic rxDataValid,
	output logic [7:0] rxData,
	output logic txDataReq,
	input wire logic [7:0] txData,
	output logic memoryReset,
	output logic badSequence
);
	// ************************************************************
	// decode table
	// ************************************************************
	function automatic cmd_decoder_pkg::cmd_info_t lookup(input logic [7:0] op);
		cmd_decoder_pkg::cmd_info_t i;
		i = '{cmd_decoder_pkg::CMD_NONE, `ADDR_BYTES_NONE, `DUMMY_CYCLES_NONE, `DATA_NONE, `DATA_NONE, 1'b0, 1'b0};
		case (op)
			`OP_RESET_ENABLE: i.cmd = cmd_decoder_pkg::CMD_RESET_ENABLE;
			`OP_MEMORY_RESET: i.cmd = cmd_decoder_pkg::CMD_MEMORY_RESET;
			`OP_GANG_LOCK: i.cmd = cmd_decoder_pkg::CMD_GANG_LOCK;
			`OP_GANG_UNLOCK: i.cmd = cmd_decoder_pkg::CMD_GANG_UNLOCK;
			`OP_READ_IDENTITY: i = '{cmd_decoder_pkg::CMD_READ_IDENTITY, `ADDR_BYTES_NONE, `DUMMY_CYCLES_NONE,
				`DATA_THREE, `DATA_THREE, 1'b1, 1'b0};
			`OP_READ_PARAM_TABLE: i = '{cmd_decoder_pkg::CMD_READ_PARAM_TABLE, `ADDR_BYTES_THREE, `DUMMY_CYCLES_EIGHT,
				`DATA_NONE, `DATA_UNBOUNDED, 1'b1, 1'b0};
			`OP_READ_STATUS: i = '{cmd_decoder_pkg::CMD_READ_STATUS, `ADDR_BYTES_NONE, `DUMMY_CYCLES_NONE,
				`DATA_ONE, `DATA_ONE, 1'b1, 1'b0};
			`OP_READ_CONFIG: i = '{cmd_decoder_pkg::CMD_READ_CONFIG, `ADDR_BYTES_NONE, `DUMMY_CYCLES_NONE,
				`DATA_ONE, `DATA_ONE, 1'b1, 1'b0};
			`OP_WRITE_STATUS_CONFIG: i = '{cmd_decoder_pkg::CMD_WRITE_STATUS_CONFIG, `ADDR_BYTES_NONE,
				`DUMMY_CYCLES_NONE, `DATA_ONE, `DATA_TWO, 1'b0, 1'b0};
			`OP_READ_CONFIG_TWO: i = '{cmd_decoder_pkg::CMD_READ_CONFIG_TWO, `ADDR_BYTES_FOUR, `DUMMY_CYCLES_NONE,
				`DATA_ONE, `DATA_ONE, 1'b1, 1'b0};
			`OP_WRITE_CONFIG_TWO: i = '{cmd_decoder_pkg::CMD_WRITE_CONFIG_TWO, `ADDR_BYTES_FOUR, `DUMMY_CYCLES_NONE,
				`DATA_ONE, `DATA_ONE, 1'b0, 1'b0};
			`OP_READ_SECURITY: i = '{cmd_decoder_pkg::CMD_READ_SECURITY, `ADDR_BYTES_NONE, `DUMMY_CYCLES_NONE,
				`DATA_ONE, `DATA_ONE, 1'b1, 1'b0};
			`OP_WRITE_SECURITY: i.cmd = cmd_decoder_pkg::CMD_WRITE_SECURITY;
			`OP_READ_BOOT: i = '{cmd_decoder_pkg::CMD_READ_BOOT, `ADDR_BYTES_NONE, `DUMMY_CYCLES_NONE,
				`DATA_ONE, `DATA_FOUR, 1'b1, 1'b0};
			`OP_WRITE_BOOT: i = '{cmd_decoder_pkg::CMD_WRITE_BOOT, `ADDR_BYTES_NONE, `DUMMY_CYCLES_NONE,
				`DATA_FOUR, `DATA_FOUR, 1'b0, 1'b0};
			`OP_ERASE_BOOT: i.cmd = cmd_decoder_pkg::CMD_ERASE_BOOT;
			`OP_SET_BURST_LEN: i = '{cmd_decoder_pkg::CMD_SET_BURST_LEN, `ADDR_BYTES_NONE, `DUMMY_CYCLES_NONE,
				`DATA_ONE, `DATA_ONE, 1'b0, 1'b0};
			`OP_ENTER_OTP: i.cmd = cmd_decoder_pkg::CMD_ENTER_OTP;
			`OP_EXIT_OTP: i.cmd = cmd_decoder_pkg::CMD_EXIT_OTP;
			`OP_WRITE_LOCKREG: i = '{cmd_decoder_pkg::CMD_WRITE_LOCKREG, `ADDR_BYTES_NONE, `DUMMY_CYCLES_NONE,
				`DATA_ONE, `DATA_ONE, 1'b0, 1'b0};
			`OP_READ_LOCKREG: i = '{cmd_decoder_pkg::CMD_READ_LOCKREG, `ADDR_BYTES_NONE, `DUMMY_CYCLES_NONE,
				`DATA_ONE, `DATA_ONE, 1'b1, 1'b0};
			`OP_PROGRAM_PERSIST_PROT: i = '{cmd_decoder_pkg::CMD_PROGRAM_PERSIST_PROT, `ADDR_BYTES_FOUR,
				`DUMMY_CYCLES_NONE, `DATA_NONE, `DATA_NONE, 1'b0, 1'b0};
			`OP_READ_PERSIST_PROT: i = '{cmd_decoder_pkg::CMD_READ_PERSIST_PROT, `ADDR_BYTES_FOUR, `DUMMY_CYCLES_NONE,
				`DATA_ONE, `DATA_ONE, 1'b1, 1'b0};
			`OP_ERASE_PERSIST_PROT: i.cmd = cmd_decoder_pkg::CMD_ERASE_PERSIST_PROT;
			`OP_WRITE_DYN_PROT: i = '{cmd_decoder_pkg::CMD_WRITE_DYN_PROT, `ADDR_BYTES_FOUR, `DUMMY_CYCLES_NONE,
				`DATA_ONE, `DATA_ONE, 1'b0, 1'b0};
			`OP_READ_DYN_PROT: i = '{cmd_decoder_pkg::CMD_READ_DYN_PROT, `ADDR_BYTES_FOUR, `DUMMY_CYCLES_NONE,
				`DATA_ONE, `DATA_ONE, 1'b1, 1'b0};
			`OP_READ_PASSCODE: i = '{cmd_decoder_pkg::CMD_READ_PASSCODE, `ADDR_BYTES_FOUR, `DUMMY_CYCLES_EIGHT,
				`DATA_EIGHT, `DATA_EIGHT, 1'b1, 1'b1};
			`OP_WRITE_PASSCODE: i = '{cmd_decoder_pkg::CMD_WRITE_PASSCODE, `ADDR_BYTES_FOUR, `DUMMY_CYCLES_NONE,
				`DATA_EIGHT, `DATA_EIGHT, 1'b0, 1'b1};
			`OP_PASSCODE_UNLOCK: i = '{cmd_decoder_pkg::CMD_PASSCODE_UNLOCK, `ADDR_BYTES_FOUR, `DUMMY_CYCLES_NONE,
				`DATA_EIGHT, `DATA_EIGHT, 1'b0, 1'b1};
			default: i.cmd = cmd_decoder_pkg::CMD_NONE;
		endcase
		return i;
	endfunction : lookup

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic csLevel;
	logic csRose;
	logic csFell;
	logic sclkLevel;
	logic sclkRose;
	logic sclkFell;
	logic sdiLevel;
	pin_sync csSync (.ref_clk(ref_clk), .rst(rst), .pinIn(chipSelect_n), .resetLevel(1'b1),
		.level(csLevel), .rose(csRose), .fell(csFell));
	pin_sync sclkSync (.ref_clk(ref_clk), .rst(rst), .pinIn(serialClock), .resetLevel(1'b0),
		.level(sclkLevel), .rose(sclkRose), .fell(sclkFell));
	pin_sync sdiSync (.ref_clk(ref_clk), .rst(rst), .pinIn(serialIn), .resetLevel(1'b0),
		.level(sdiLevel), .rose(), .fell());

	// ************************************************************
	// frame state
	// ************************************************************
	cmd_decoder_pkg::phase_t phase_reg;
	cmd_decoder_pkg::phase_t phase_next;
	cmd_decoder_pkg::cmd_info_t info_reg;
	cmd_decoder_pkg::cmd_info_t opInfo;
	logic [7:0] rxShift_reg;
	logic [2:0] bitCount_reg;
	logic [2:0] addrCount_reg;
	logic [3:0] dummyCount_reg;
	logic [3:0] dataCount_reg;
	logic resetArmed_reg;
	logic [31:0] addr_reg;
	logic inFrame;
	logic bitTake;
	logic byteDoneIn;
	logic [7:0] byteIn;
	logic addrLast;
	logic dataFull;
	logic txShift;
	logic txByteDone;
	logic txLoad;
	logic txBit;
	logic frameEnd;
	logic frameCmdEnd;
	logic lengthOk;

	// a full byte is seen on the rising edge that brings the eighth bit
	assign inFrame = ~csLevel;
	assign bitTake = inFrame & sclkRose;
	assign byteDoneIn = bitTake & (bitCount_reg == `BIT_LAST);
	assign byteIn = {rxShift_reg[6:0], sdiLevel};
	assign opInfo = lookup(byteIn);
	assign addrLast = (addrCount_reg == info_reg.addrBytes - 3'h1);
	assign dataFull = (info_reg.dataMax != `DATA_UNBOUNDED) & (dataCount_reg == info_reg.dataMax);
	assign frameEnd = csRose;
	assign lengthOk = (phase_reg == cmd_decoder_pkg::PH_DONE)
		| ((phase_reg == cmd_decoder_pkg::PH_DATA) & (dataCount_reg >= info_reg.dataMin) & (bitCount_reg == `BIT_FIRST));
	assign frameCmdEnd = frameEnd & lengthOk & (info_reg.cmd != cmd_decoder_pkg::CMD_NONE);
	// device drives only in the data phase of a read; falling edges move bits
	assign txShift = inFrame & sclkFell & (phase_reg == cmd_decoder_pkg::PH_DATA) & info_reg.isRead
		& (bitCount_reg != `BIT_FIRST);
	assign txLoad = inFrame & sclkFell & (phase_reg == cmd_decoder_pkg::PH_DATA) & info_reg.isRead
		& (bitCount_reg == `BIT_FIRST) & ~dataFull;

	always_comb begin
		phase_next = phase_reg;
		if (csFell) begin
			phase_next = cmd_decoder_pkg::PH_OPCODE;
		end else if (frameEnd) begin
			phase_next = cmd_decoder_pkg::PH_OPCODE;
		end else if (byteDoneIn) begin
			case (phase_reg)
				cmd_decoder_pkg::PH_OPCODE: begin
					if (opInfo.cmd == cmd_decoder_pkg::CMD_NONE) phase_next = cmd_decoder_pkg::PH_STANDBY;
					else if (opInfo.addrBytes != `ADDR_BYTES_NONE) phase_next = cmd_decoder_pkg::PH_ADDR;
					else if (opInfo.dataMax != `DATA_NONE) phase_next = cmd_decoder_pkg::PH_DATA;
					else phase_next = cmd_decoder_pkg::PH_DONE;
				end
				cmd_decoder_pkg::PH_ADDR: begin
					if (info_reg.zeroAddr & (byteIn != `BYTE_ZERO)) phase_next = cmd_decoder_pkg::PH_STANDBY;
					else if (addrLast & (info_reg.dummyCycles != `DUMMY_CYCLES_NONE))
						phase_next = cmd_decoder_pkg::PH_DUMMY;
					else if (addrLast & (info_reg.dataMax != `DATA_NONE)) phase_next = cmd_decoder_pkg::PH_DATA;
					else if (addrLast) phase_next = cmd_decoder_pkg::PH_DONE;
				end
				cmd_decoder_pkg::PH_DATA: begin
					if (dataFull) phase_next = cmd_decoder_pkg::PH_STANDBY;
				end
				cmd_decoder_pkg::PH_DONE: phase_next = cmd_decoder_pkg::PH_STANDBY;
				default: phase_next = phase_reg;
			endcase
		end else if (bitTake & (phase_reg == cmd_decoder_pkg::PH_DUMMY)
			& (dummyCount_reg == info_reg.dummyCycles - 4'h1)) begin
			phase_next = (info_reg.dataMax != `DATA_NONE) ? cmd_decoder_pkg::PH_DATA : cmd_decoder_pkg::PH_DONE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			phase_reg <= cmd_decoder_pkg::PH_OPCODE;
			info_reg <= '{cmd_decoder_pkg::CMD_NONE, `ADDR_BYTES_NONE, `DUMMY_CYCLES_NONE, `DATA_NONE, `DATA_NONE,
				1'b0, 1'b0};
			rxShift_reg <= `BYTE_ZERO;
			bitCount_reg <= `BIT_FIRST;
			addrCount_reg <= `ADDR_BYTES_NONE;
			dummyCount_reg <= `DUMMY_CYCLES_NONE;
			dataCount_reg <= `DATA_NONE;
			addr_reg <= 32'h0000_0000;
		end else begin
			phase_reg <= phase_next;
			if (csFell | frameEnd) begin
				bitCount_reg <= `BIT_FIRST;
				addrCount_reg <= `ADDR_BYTES_NONE;
				dummyCount_reg <= `DUMMY_CYCLES_NONE;
				dataCount_reg <= `DATA_NONE;
				addr_reg <= 32'h0000_0000;
			end else if (bitTake & (phase_reg == cmd_decoder_pkg::PH_DUMMY)) begin
				dummyCount_reg <= dummyCount_reg + 4'h1;
			end else if (bitTake & (phase_reg != cmd_decoder_pkg::PH_STANDBY)) begin
				rxShift_reg <= byteIn;
				bitCount_reg <= bitCount_reg + 3'h1;
				if (byteDoneIn & (phase_reg == cmd_decoder_pkg::PH_OPCODE)) info_reg <= opInfo;
				if (byteDoneIn & (phase_reg == cmd_decoder_pkg::PH_ADDR)) begin
					addr_reg <= {addr_reg[23:0], byteIn};
					addrCount_reg <= addrCount_reg + 3'h1;
				end
				if (byteDoneIn & (phase_reg == cmd_decoder_pkg::PH_DATA) & ~dataFull
					& (info_reg.dataMax != `DATA_UNBOUNDED)) dataCount_reg <= dataCount_reg + 4'h1;
			end
			if (txByteDone & ~dataFull & (info_reg.dataMax != `DATA_UNBOUNDED)) dataCount_reg <= dataCount_reg + 4'h1;
		end
	end

	// ************************************************************
	// outputs and reset arming
	// ************************************************************
	shift_out_byte txShifter (.ref_clk(ref_clk), .rst(rst), .load(txLoad), .loadByte(txData), .shift(txShift),
		.serialOut(txBit), .byteDone(txByteDone));

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			serialOut <= 1'b0;
			serialOutEn <= 1'b0;
			cmdValid <= 1'b0;
			cmdCode <= cmd_decoder_pkg::CMD_NONE;
			cmdAddr <= 32'h0000_0000;
			cmdDataCount <= `DATA_NONE;
			rxDataValid <= 1'b0;
			rxData <= `BYTE_ZERO;
			txDataReq <= 1'b0;
			memoryReset <= 1'b0;
			badSequence <= 1'b0;
			resetArmed_reg <= 1'b0;
		end else begin
			serialOut <= txBit;
			// released in standby and outside reads, so the line floats
			serialOutEn <= inFrame & info_reg.isRead & (phase_reg == cmd_decoder_pkg::PH_DATA);
			cmdValid <= frameCmdEnd & (info_reg.cmd != cmd_decoder_pkg::CMD_RESET_ENABLE)
				& (info_reg.cmd != cmd_decoder_pkg::CMD_MEMORY_RESET);
			if (frameCmdEnd) begin
				cmdCode <= info_reg.cmd;
				cmdAddr <= addr_reg;
				cmdDataCount <= dataCount_reg;
			end
			rxDataValid <= byteDoneIn & (phase_reg == cmd_decoder_pkg::PH_DATA) & ~info_reg.isRead & ~dataFull;
			if (byteDoneIn) rxData <= byteIn;
			// raised on the rising edge, half a serial clock ahead of the falling edge that loads the next byte
			txDataReq <= inFrame & sclkRose & (phase_next == cmd_decoder_pkg::PH_DATA) & opInfoIsRead(phase_reg)
				& ((bitCount_reg == `BIT_LAST) | (phase_reg == cmd_decoder_pkg::PH_DUMMY))
				& ~((phase_reg == cmd_decoder_pkg::PH_DATA) & (dataCount_reg + 4'h1 == info_reg.dataMax));
			badSequence <= byteDoneIn & (phase_next == cmd_decoder_pkg::PH_STANDBY)
				& (phase_reg != cmd_decoder_pkg::PH_STANDBY);
			memoryReset <= frameCmdEnd & (info_reg.cmd == cmd_decoder_pkg::CMD_MEMORY_RESET) & resetArmed_reg;
			// any completed or broken frame other than reset-enable disarms
			if (frameEnd & (phase_reg != cmd_decoder_pkg::PH_OPCODE | bitCount_reg != `BIT_FIRST))
				resetArmed_reg <= frameCmdEnd & (info_reg.cmd == cmd_decoder_pkg::CMD_RESET_ENABLE);
		end
	end

	function automatic logic opInfoIsRead(input cmd_decoder_pkg::phase_t ph);
		opInfoIsRead = (ph == cmd_decoder_pkg::PH_OPCODE) ? opInfo.isRead : info_reg.isRead;
	endfunction : opInfoIsRead
endmodule : spi_register_command_decoder
`default_nettype wire

// >>> tb/spi_register_command_decoder_asserts.sv
// concurrent checks on the ports of the serial register command decoder
`timescale 1ns/1ps
`default_nettype none
module cmd_decoder_checker (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic chipSelect_n,
	input wire logic serialOutEn,
	input wire logic cmdValid,
	input wire cmd_decoder_pkg::command_t cmdCode,
	input wire logic [31:0] cmdAddr,
	input wire logic [3:0] cmdDataCount,
	input wire logic rxDataValid,
	input wire logic memoryReset,
	input wire logic badSequence
);
	// ********************
	// standby tracker: set by a bad sequence, cleared by the next select fall
	// ********************
	logic quietReg;
	always_ff @(posedge ref_clk) begin
		if (rst) quietReg <= 1'b0;
		else quietReg <= badSequence | (quietReg & !$fell(chipSelect_n));
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ********************
	// properties
	// ********************
	chk_valid_pulse: assert property (cmdValid |=> !cmdValid)
		else $error("cmdValid longer than one cycle");
	chk_valid_deselect: assert property (cmdValid |-> chipSelect_n && !memoryReset)
		else $error("cmdValid while selected");
	chk_idle_released: assert property (chipSelect_n [*8] |-> !serialOutEn && !rxDataValid)
		else $error("activity while deselected");
	chk_bad_standby: assert property (quietReg |-> !serialOutEn && !cmdValid)
		else $error("activity after bad sequence");
	chk_reset_pulse: assert property (memoryReset |=> !memoryReset [*4])
		else $error("memoryReset repeated");
	chk_rx_framed: assert property (rxDataValid |-> !chipSelect_n ##1 !rxDataValid)
		else $error("rxDataValid outside frame");
	chk_ident_count: assert property (cmdValid && cmdCode == cmd_decoder_pkg::CMD_READ_IDENTITY
		|-> cmdDataCount == 4'h3)
		else $error("identity count wrong");
	chk_table_addr: assert property (cmdValid && cmdCode == cmd_decoder_pkg::CMD_READ_PARAM_TABLE
		|-> cmdDataCount == 4'h0 && cmdAddr[31:24] == 8'h00)
		else $error("table read fields wrong");
	chk_boot_count: assert property (cmdValid && cmdCode == cmd_decoder_pkg::CMD_WRITE_BOOT
		|-> cmdDataCount == 4'h4)
		else $error("boot write count wrong");
	chk_pass_zero: assert property (cmdValid && cmdCode inside {cmd_decoder_pkg::CMD_READ_PASSCODE,
		cmd_decoder_pkg::CMD_WRITE_PASSCODE, cmd_decoder_pkg::CMD_PASSCODE_UNLOCK}
		|-> cmdAddr == 32'h0000_0000 && cmdDataCount == 4'h8)
		else $error("passcode fields wrong");
endmodule : cmd_decoder_checker
bind spi_register_command_decoder cmd_decoder_checker chk (.ref_clk(ref_clk), .rst(rst),
	.chipSelect_n(chipSelect_n), .serialOutEn(serialOutEn), .cmdValid(cmdValid), .cmdCode(cmdCode),
	.cmdAddr(cmdAddr), .cmdDataCount(cmdDataCount), .rxDataValid(rxDataValid),
	.memoryReset(memoryReset), .badSequence(badSequence));
`default_nettype wire

// >>> tb/spi_host_model.sv
// behavioural serial flash host that frames commands for the decoder
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input wire logic ref_clk,
	input wire logic serialOut,
	input wire logic serialOutEn,
	output logic chipSelect_n,
	output logic serialClock,
	output logic serialIn
);
	logic [7:0] rxq[$];
	initial begin
		chipSelect_n = 1'b1;
		serialClock = 1'b0;
		serialIn = 1'b0;
	end
	// half of a 320 ns serial period; clock stands low outside frames
	task automatic half();
		repeat (4) @(negedge ref_clk);
	endtask : half
	// released line toggles so a stale bit cannot pass for data
	task automatic bitx(input logic b, input logic own, output logic s);
		serialIn = own ? b : ~serialIn;
		half();
		serialClock = 1'b1;
		half();
		s = serialOutEn ? serialOut : ~serialOut; // late sample; a released line reads back inverted
		serialClock = 1'b0;
	endtask : bitx
	// ********************
	// one frame: opcode and address/write bytes, dummy clocks, read bytes
	// ********************
	task automatic frame(input logic [7:0] q[$], input int dummy, input int nrd);
		logic s;
		logic [7:0] b;
		rxq = {};
		chipSelect_n = 1'b0;
		half();
		foreach (q[i]) for (int k = 7; k >= 0; k--) bitx(q[i][k], 1'b1, s);
		repeat (dummy) bitx(1'b0, 1'b0, s);
		repeat (nrd) begin
			for (int k = 7; k >= 0; k--) begin
				bitx(1'b0, 1'b0, s);
				b[k] = s;
			end
			rxq.push_back(b);
		end
		half();
		chipSelect_n = 1'b1;
		serialIn = ~serialIn;
		repeat (4) half();
	endtask : frame
endmodule : spi_host_model
`default_nettype wire

// >>> tb/tb_spi_register_command_decoder.sv
// self-checking bench for the serial register command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_spi_register_command_decoder;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic chipSelect_n, serialClock, serialIn, serialOut, serialOutEn, cmdValid, rxDataValid, txDataReq;
	logic memoryReset, badSequence;
	logic [7:0] rxData;
	logic [7:0] txData = 8'h00;
	logic [31:0] cmdAddr;
	logic [3:0] cmdDataCount;
	cmd_decoder_pkg::command_t cmdCode;
	logic [31:0] seed = 32'h0000_17A7;
	int errCount = 0, nChecks = 0, nValid, nRx, nRst, nBad, nEn, nReq;
	always #20 ref_clk = ~ref_clk;
	spi_register_command_decoder dut (.ref_clk(ref_clk), .rst(rst), .chipSelect_n(chipSelect_n),
		.serialClock(serialClock), .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
		.cmdValid(cmdValid), .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdDataCount(cmdDataCount),
		.rxDataValid(rxDataValid), .rxData(rxData), .txDataReq(txDataReq), .txData(txData),
		.memoryReset(memoryReset), .badSequence(badSequence));
	spi_host_model host (.ref_clk(ref_clk), .serialOut(serialOut), .serialOutEn(serialOutEn), .chipSelect_n(chipSelect_n),
		.serialClock(serialClock), .serialIn(serialIn));
	// ********************
	// command model: opcode, address bytes, dummy clocks, data bytes, read
	// ********************
	localparam logic [7:0] OPS [29] = '{8'h66, 8'h99, 8'h7E, 8'h98, 8'h9F, 8'h5A, 8'h05, 8'h15, 8'h01, 8'h71,
		8'h72, 8'h2B, 8'h2F, 8'h16, 8'h17, 8'h18, 8'hC0, 8'hB1, 8'hC1, 8'h2C, 8'h2D, 8'hE3, 8'hE4, 8'hE2,
		8'hE1, 8'hE0, 8'h27, 8'h28, 8'h29};
	localparam int AB [29] = '{0, 0, 0, 0, 0, 3, 0, 0, 0, 4, 4, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 4, 0, 4, 4, 4, 4, 4, 4};
	localparam int DM [29] = '{0, 0, 0, 0, 0, 8, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 8, 0, 0};
	localparam int DN [29] = '{0, 0, 0, 0, 3, 2, 1, 1, 2, 1, 1, 1, 0, 4, 4, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1, 1, 8, 8, 8};
	localparam int RD [29] = '{0, 0, 0, 0, 1, 1, 1, 1, 0, 1, 0, 1, 0, 1, 0, 0, 0, 0, 0, 0, 1, 0, 0, 1, 0, 1, 1, 0, 0};
	always @(posedge ref_clk) begin
		nValid += (cmdValid === 1'b1);
		nRx += (rxDataValid === 1'b1);
		nRst += (memoryReset === 1'b1);
		nBad += (badSequence === 1'b1);
		nEn += (serialOutEn === 1'b1);
		nReq += (txDataReq === 1'b1);
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		nChecks++;
		if (got !== exp) begin
			errCount++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic endSim();
		if (errCount == 0 && nChecks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : endSim
	task automatic clr();
		{nValid, nRx, nRst, nBad, nEn, nReq} = '0;
	endtask : clr
	task automatic op(input logic [7:0] o);
		clr();
		host.frame({o}, 0, 0);
	endtask : op
	task automatic bad(input logic [7:0] q[$], input int expBad);
		clr();
		host.frame(q, 0, 0);
		check("bad pulse", expBad, nBad);
		check("bad valid", 0, nValid);
		check("bad drive", 0, nEn);
	endtask : bad
	task automatic runCmd(input int i, input int n);
		logic [7:0] q[$];
		logic [31:0] a;
		logic [7:0] last;
		a = (i > 25) ? 32'h0000_0000 : rnd();
		if (AB[i] == 3) a[31:24] = 8'h00;
		txData = 8'(rnd());
		q = {OPS[i]};
		last = 8'h00;
		for (int k = AB[i] - 1; k >= 0; k--) q.push_back(a[8 * k +: 8]);
		for (int k = 0; k < n && RD[i] == 0; k++) begin
			last = 8'(rnd());
			q.push_back(last);
		end
		clr();
		host.frame(q, DM[i], (RD[i] == 1) ? n : 0);
		check("valid", 1, nValid);
		check("code", i + 1, cmdCode);
		check("count", (i == 5) ? 0 : n, cmdDataCount);
		if (AB[i] > 0) check("address", a, cmdAddr);
		check("rx bytes", (RD[i] == 1) ? 0 : n, nRx);
		if (RD[i] == 0 && n > 0) check("rx data", last, rxData);
		check("tx bytes", (RD[i] == 1) ? n : 0, host.rxq.size());
		foreach (host.rxq[k]) check("tx data", txData, host.rxq[k]);
		check("tx requests", (RD[i] == 0) ? 0 : n + (i == 5 || n < DN[i]), nReq);
		if (RD[i] == 0) check("drive", 0, nEn);
	endtask : runCmd
	// ********************
	// main sequence and watchdog
	// ********************
	initial begin
		repeat (20) @(negedge ref_clk);
		rst = 1'b0;
		repeat (8) @(negedge ref_clk);
		op(8'h66);
		op(8'h99);
		check("reset pulse", 1, nRst);
		check("reset valid", 0, nValid);
		op(8'h66);
		runCmd(6, 1);
		op(8'h99);
		check("reset disarmed", 0, nRst);
		for (int i = 2; i < 29; i++) runCmd(i, DN[i]);
		runCmd(8, 1);
		runCmd(13, 1);
		bad({8'hA7, 8'h05}, 1);
		bad({8'hC0, 8'h12, 8'h34}, 1);
		bad({8'h2F, 8'h00}, 1);
		bad({8'h28, 8'h01, 8'h00, 8'h00, 8'h00}, 1);
		bad({8'h17, 8'h55}, 0);
		endSim();
	end
	initial begin
		#3_000_000;
		errCount++;
		endSim();
	end
endmodule : tb_spi_register_command_decoder
`default_nettype wire
